// [verilog/wor_pkg.sv]
// Constants, field layouts and carrier types of the wake-on-radio sleep timer
package wor_pkg;

  // ***********************************************************************
  // Bus and register map
  // ***********************************************************************
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_INTERVAL_HIGH = 10'h01e;
  localparam logic [9:0] IDX_INTERVAL_LOW = 10'h01f;
  localparam logic [9:0] IDX_WAKE_CONTROL = 10'h020;
  localparam logic [9:0] IDX_STATUS = 10'h030;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Reset values
  localparam logic [7:0] RST_INTERVAL_HIGH = 8'h87;
  localparam logic [7:0] RST_INTERVAL_LOW = 8'h6b;
  localparam logic RST_RC_OSC_POWERDOWN = 1'h1;
  localparam logic [2:0] RST_SECOND_DELAY = 3'h7;
  localparam logic RST_CAL_EN = 1'h1;
  localparam logic [1:0] RST_RESOLUTION = 2'h0;

  // Wake control field positions
  localparam int RC_OSC_POWERDOWN_BIT = 7;
  localparam int DLY_MSB = 6;
  localparam int DLY_LSB = 4;
  localparam int CAL_EN_BIT = 3;
  localparam int RES_MSB = 1;
  localparam int RES_LSB = 0;

  // Status field positions
  localparam int ST_CAL_BUSY = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_DELAY = 2;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int XTAL_PER_RC = 750;
  localparam int CAL_RC_PERIODS = 16;

  // Second-event delay in RC periods, code 7 in the top slot
  localparam logic [7:0][5:0] DELAY_TABLE = {6'h30, 6'h20, 6'h18, 6'h10, 6'h0c, 6'h08, 6'h06, 6'h04};
  // Last prescaler value per resolution code: 1, 32, 1024, 32768 periods
  localparam logic [3:0][14:0] RES_LAST = {15'h7fff, 15'h03ff, 15'h001f, 15'h0000};

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef enum logic [1:0] {
    TMR_IDLE = 2'h0,
    TMR_COUNT = 2'h1,
    TMR_DELAY = 2'h3
  } tmr_e;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic wake_event;
    logic second_event;
    logic rc_osc_powerdown;
    logic cal_busy;
  } events_s;

  typedef struct packed {
    apb_rsp_s rsp;
    events_s ev;
    logic [7:0] interval_high;
    logic [7:0] interval_low;
    logic rc_osc_powerdown;
    logic [2:0] second_event_delay;
    logic rc_osc_cal_enable;
    logic [1:0] wake_timer_resolution;
    tmr_e tmr;
    logic [7:0] cal_cnt;
    logic [14:0] pre_cnt;
    logic [15:0] wake_cnt;
    logic [5:0] dly_cnt;
  } wor_state_s;

endpackage : wor_pkg

// [verilog/rc_tick_divider.sv]
// Divider that turns the crystal-rate clock into the RC oscillator tick enable
module rc_tick_divider #(
  parameter int DIV = 750
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and tick
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  // Counter and its registered tick flag
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_s;

  div_state_s div_q;
  div_state_s div_d;

  // ***********************************************************************
  // Counter
  // ***********************************************************************
  // Held at zero while stopped so the first tick comes a full period later
  always_comb begin
    div_d = div_q;
    if (!run) begin
      div_d.cnt = '0;
      div_d.tick = 1'b0;
    end else begin
      div_d.tick = (div_q.cnt == LAST);
      div_d.cnt = (div_q.cnt == LAST) ? '0 : div_q.cnt + CW'(1);
    end
  end

  // Register the copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  assign tick = div_q.tick;

endmodule : rc_tick_divider

// [verilog/wake_on_radio_timer.sv]
// Wake-on-radio sleep timer with its APB register file
module wake_on_radio_timer #(
  parameter int XTAL_DIV = wor_pkg::XTAL_PER_RC,
  parameter int CAL_PERIODS = wor_pkg::CAL_RC_PERIODS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [wor_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer events and oscillator control
  output wor_pkg::events_s events
);

  // Whole state and its next value
  wor_pkg::wor_state_s q;
  wor_pkg::wor_state_s d;
  // Bus bundle and its decode
  wor_pkg::apb_req_s req;
  logic [9:0] index;
  logic aligned;
  // Tick enable and count limits
  logic rc_tick;
  logic [15:0] interval;
  logic [15:0] interval_last;

  // ***********************************************************************
  // Request carrier
  // ***********************************************************************
  // Keeps the next-state logic free of loose pin names
  // Gather the bus pins into one bundle
  always_comb begin
    req.paddr = paddr;
    req.pwrite = pwrite;
    req.pwdata = pwdata;
    req.psel = psel;
    req.penable = penable;
  end

  assign index = req.paddr[wor_pkg::ADDR_W-1:2];
  assign aligned = (req.paddr[1:0] == wor_pkg::WORD_ALIGN);
  assign interval = {q.interval_high, q.interval_low};
  // A zero count behaves as one step, so the timer never stalls
  // Trade-off: counts 0 and 1 give the same period
  assign interval_last = (interval == 16'h0000) ? 16'h0000 : interval - 16'h0001;

  // ***********************************************************************
  // RC oscillator tick
  // ***********************************************************************
  // One enable at crystal rate over XTAL_DIV; no second clock domain
  // Divider restarts on power-up, so the first tick is a full period out
  // tick runs only while powered up
  rc_tick_divider #(
    .DIV(XTAL_DIV)
  ) i_rc_tick_divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(!q.rc_osc_powerdown),
    .tick(rc_tick)
  );

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  // Bus, calibration and timer all in one pass
  // One pass keeps bus writes and timer updates in step
  // Order: readback, write decode, calibration, then the timer
  always_comb begin
    logic [7:0] ctrl_rd;
    logic [7:0] stat_rd;
    logic mapped;
    logic wr;
    logic cal_start;
    d = q;
    ctrl_rd = 8'h00;
    stat_rd = 8'h00;
    mapped = 1'b0;
    wr = 1'b0;
    cal_start = 1'b0;
    d.rsp.pready = 1'b0;
    d.rsp.pslverr = 1'b0;
    d.ev.wake_event = 1'b0;
    d.ev.second_event = 1'b0;

    // *******************************************************************
    // Register access
    // *******************************************************************
    // Readback images; control bit 2 reads zero
    ctrl_rd[wor_pkg::RC_OSC_POWERDOWN_BIT] = q.rc_osc_powerdown;
    ctrl_rd[wor_pkg::DLY_MSB:wor_pkg::DLY_LSB] = q.second_event_delay;
    ctrl_rd[wor_pkg::CAL_EN_BIT] = q.rc_osc_cal_enable;
    ctrl_rd[wor_pkg::RES_MSB:wor_pkg::RES_LSB] = q.wake_timer_resolution;
    stat_rd[wor_pkg::ST_CAL_BUSY] = q.ev.cal_busy;
    stat_rd[wor_pkg::ST_RUNNING] = (q.tmr != wor_pkg::TMR_IDLE);
    stat_rd[wor_pkg::ST_DELAY] = (q.tmr == wor_pkg::TMR_DELAY);

    // Setup phase: decode and latch read data, answer in the access cycle
    // Every access takes exactly one wait-free access cycle
    if (req.psel && !req.penable) begin
      d.rsp.pready = 1'b1;
      d.rsp.prdata = 32'h0000_0000;
      if (aligned) begin
        unique case (index)
          wor_pkg::IDX_INTERVAL_HIGH: begin
            mapped = 1'b1;
            d.rsp.prdata[7:0] = q.interval_high;
          end
          wor_pkg::IDX_INTERVAL_LOW: begin
            mapped = 1'b1;
            d.rsp.prdata[7:0] = q.interval_low;
          end
          wor_pkg::IDX_WAKE_CONTROL: begin
            mapped = 1'b1;
            d.rsp.prdata[7:0] = ctrl_rd;
          end
          wor_pkg::IDX_STATUS: begin
            mapped = 1'b1;
            // Live view; reading it clears nothing
            d.rsp.prdata[7:0] = stat_rd;
          end
          default: begin
            mapped = 1'b0;
          end
        endcase
      end
      // Unmapped, misaligned, or a write to the read-only status word
      d.rsp.pslverr = !mapped || (req.pwrite && index == wor_pkg::IDX_STATUS);
    end

    // Error flag is settled from the setup cycle, so a refused write never lands
    // Writes land on the edge that completes the access phase
    // wr is dropped again below for writes that decode to nothing
    wr = req.psel && req.penable && req.pwrite && q.rsp.pready && !q.rsp.pslverr;
    if (wr) begin
      unique case (index)
        wor_pkg::IDX_INTERVAL_HIGH: begin
          d.interval_high = req.pwdata[7:0];
        end
        wor_pkg::IDX_INTERVAL_LOW: begin
          d.interval_low = req.pwdata[7:0];
        end
        wor_pkg::IDX_WAKE_CONTROL: begin
          d.rc_osc_powerdown = req.pwdata[wor_pkg::RC_OSC_POWERDOWN_BIT];
          d.second_event_delay = req.pwdata[wor_pkg::DLY_MSB:wor_pkg::DLY_LSB];
          d.rc_osc_cal_enable = req.pwdata[wor_pkg::CAL_EN_BIT];
          d.wake_timer_resolution = req.pwdata[wor_pkg::RES_MSB:wor_pkg::RES_LSB];
          // Only a real 1-to-0 change of the bit starts it, not a rewrite of 0
          // power-up kicks calibration
          cal_start = q.rc_osc_powerdown && !req.pwdata[wor_pkg::RC_OSC_POWERDOWN_BIT]
                      && req.pwdata[wor_pkg::CAL_EN_BIT];
        end
        default: begin
          // Refused by the error flag already
          wr = 1'b0;
        end
      endcase
    end

    // *******************************************************************
    // Calibration
    // *******************************************************************
    // Calibration runs a fixed number of RC periods; clearing enable aborts it
    // Abort looks at next-value bits, so a clearing write stops it at once
    // Start wins over abort when both fall in one cycle
    if (cal_start) begin
      d.ev.cal_busy = 1'b1;
      d.cal_cnt = 8'h00;
    end else if (q.ev.cal_busy) begin
      if (!d.rc_osc_cal_enable || d.rc_osc_powerdown) begin
        d.ev.cal_busy = 1'b0;
      end else if (rc_tick) begin
        if (q.cal_cnt == 8'(CAL_PERIODS - 1)) begin
          d.ev.cal_busy = 1'b0;
        end else begin
          d.cal_cnt = q.cal_cnt + 8'h01;
        end
      end
    end
    d.ev.rc_osc_powerdown = d.rc_osc_powerdown;

    // *******************************************************************
    // Wake timer
    // *******************************************************************
    // Events are single-cycle pulses, cleared at the top of the pass
    // Changing resolution or count mid-interval is safe: the compares use >=
    // Wake timer: held idle while powered down or calibrating
    if (d.rc_osc_powerdown || d.ev.cal_busy) begin
      d.tmr = wor_pkg::TMR_IDLE;
      d.pre_cnt = 15'h0000;
      d.wake_cnt = 16'h0000;
      d.dly_cnt = 6'h00;
    end else begin
      unique case (q.tmr)
        wor_pkg::TMR_IDLE: begin
          // One cycle in idle clears the counters before counting resumes
          d.tmr = wor_pkg::TMR_COUNT;
          d.pre_cnt = 15'h0000;
          d.wake_cnt = 16'h0000;
        end
        wor_pkg::TMR_COUNT, wor_pkg::TMR_DELAY: begin
          if (rc_tick) begin
            // step of 1, 32, 1024 or 32768 periods
            // code 3 gives the coarsest 32768-period step
            if (q.pre_cnt >= wor_pkg::RES_LAST[q.wake_timer_resolution]) begin
              d.pre_cnt = 15'h0000;
              if (q.wake_cnt >= interval_last) begin
                d.wake_cnt = 16'h0000;
                d.ev.wake_event = 1'b1;
                d.tmr = wor_pkg::TMR_DELAY;
                d.dly_cnt = 6'h01;
              end else begin
                d.wake_cnt = q.wake_cnt + 16'h0001;
              end
            end else begin
              d.pre_cnt = q.pre_cnt + 15'h0001;
            end
            // A wake that comes before the second event restarts the delay
            // second event after table delay
            if (q.tmr == wor_pkg::TMR_DELAY && !d.ev.wake_event) begin
              if (q.dly_cnt >= wor_pkg::DELAY_TABLE[q.second_event_delay]) begin
                d.ev.second_event = 1'b1;
                d.tmr = wor_pkg::TMR_COUNT;
              end else begin
                d.dly_cnt = q.dly_cnt + 6'h01;
              end
            end
          end
        end
        default: begin
          // Unused code 2 falls back to idle
          d.tmr = wor_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************************
  // State register
  // ***********************************************************************
  // Reset values put the oscillator down with calibration armed
  // Asynchronous reset assigns constants only
  // Every field named, so no state is left to a default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Bus answer and events quiet
      q.rsp.prdata <= 32'h0000_0000;
      q.rsp.pready <= 1'b0;
      q.rsp.pslverr <= 1'b0;
      q.ev.wake_event <= 1'b0;
      q.ev.second_event <= 1'b0;
      q.ev.cal_busy <= 1'b0;
      // Counters cleared
      q.cal_cnt <= 8'h00;
      q.pre_cnt <= 15'h0000;
      q.wake_cnt <= 16'h0000;
      q.dly_cnt <= 6'h00;
      q.interval_low <= wor_pkg::RST_INTERVAL_LOW;
      q.interval_high <= wor_pkg::RST_INTERVAL_HIGH;
      q.rc_osc_powerdown <= wor_pkg::RST_RC_OSC_POWERDOWN;
      q.ev.rc_osc_powerdown <= wor_pkg::RST_RC_OSC_POWERDOWN;
      q.second_event_delay <= wor_pkg::RST_SECOND_DELAY;
      q.rc_osc_cal_enable <= wor_pkg::RST_CAL_EN;
      q.wake_timer_resolution <= wor_pkg::RST_RESOLUTION;
      q.tmr <= wor_pkg::TMR_IDLE;
    end else begin
      q <= d;
    end
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  // All straight from the state register
  // Registered answer keeps prdata steady through the access cycle
  // No output passes through logic after the flops
  assign prdata = q.rsp.prdata;
  assign pready = q.rsp.pready;
  assign pslverr = q.rsp.pslverr;
  assign events = q.ev;

endmodule : wake_on_radio_timer

// [testbench/wor_timer_asserts.sv]
// Port-level assertions of the wake-on-radio sleep timer, bound to its top module
module wor_timer_asserts #(
  parameter int XTAL_DIV = 750,
  parameter int CAL_PERIODS = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [wor_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events
  input wire wor_pkg::events_s events
);
  // ***********************************************************************
  // Helper logic
  // ***********************************************************************
  logic [15:0] since_q;
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == 12'h080;
  // Cycles since the last wake pulse, saturating so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 16'h0000;
    end else if (events.wake_event) begin
      since_q <= 16'h0001;
    end else if (since_q != 16'hffff) begin
      since_q <= since_q + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_error: assert property (psel && !penable && paddr == 12'h004 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ctrl_read_clean: assert property (pready && !pwrite && paddr == 12'h080 |-> prdata[31:8] == 24'h0 && !prdata[2])
    else $error("control read shows unused bits");
  a_cal_on_wake: assert property (ctl_wr && events.rc_osc_powerdown && !pwdata[7] && pwdata[3] |=> events.cal_busy)
    else $error("calibration did not start");
  a_cal_disabled: assert property (ctl_wr && !pwdata[7] && !pwdata[3] |=> !events.cal_busy)
    else $error("calibration ran while disabled");
  a_pd_quiet: assert property (events.rc_osc_powerdown && $past(events.rc_osc_powerdown) |-> !events.wake_event)
    else $error("wake event while powered down");
  a_cal_quiet: assert property (events.cal_busy |-> !events.wake_event && !events.second_event)
    else $error("event during calibration");
  a_wake_pulse: assert property (events.wake_event |=> !events.wake_event)
    else $error("wake pulse longer than one cycle");
  a_second_spacing: assert property (events.second_event |-> since_q >= 3 * XTAL_DIV && since_q <= 49 * XTAL_DIV)
    else $error("second event outside delay range");
endmodule : wor_timer_asserts

bind wake_on_radio_timer wor_timer_asserts #(.XTAL_DIV(XTAL_DIV), .CAL_PERIODS(CAL_PERIODS)) i_wor_timer_asserts (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events));

// [testbench/wake_on_radio_timer_tb_top.sv]
// Self-checking APB testbench of the wake-on-radio sleep timer
module wake_on_radio_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  localparam int CALP = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wor_pkg::events_s events;
  int fail_count = 0;
  int samples_checked = 0;
  int dly[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
  int step[3] = '{1, 32, 1024};
  logic [31:0] d;
  logic e;
  int n;
`define CHECK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end

  // Short divider keeps the run well inside the budget
  wake_on_radio_timer #(.XTAL_DIV(DIV), .CAL_PERIODS(CALP)) i_wake_on_radio_timer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events));

  always #4 pclk = ~pclk;

  // ***********************************************************************
  // Bus and wait tasks
  // ***********************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Counts edges until the selected event is seen; sel 0 wake, 1 second, 2 calibration done
  task automatic wait_for(input int sel, output int cnt);
    logic hit;
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
      hit = (sel == 0) ? events.wake_event === 1'b1 : (sel == 1) ? events.second_event === 1'b1
          : events.cal_busy === 1'b0;
    end while (!hit && cnt < 20000);
    if (!hit) `CHECK("event wait", 1'b1, hit)
  endtask : wait_for

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ***********************************************************************
  // Tests
  // ***********************************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h078, 32'h0, d, e); `CHECK("interval high", 32'h87, d)
    apb(1'b0, 12'h07c, 32'h0, d, e); `CHECK("interval low", 32'h6b, d)
    apb(1'b0, 12'h080, 32'h0, d, e); `CHECK("control", 32'hf8, d)
    `CHECK("powerdown", 1'b1, events.rc_osc_powerdown)
    apb(1'b1, 12'h07c, 32'hffffffa5, d, e);
    apb(1'b0, 12'h07c, 32'h0, d, e); `CHECK("low readback", 32'ha5, d)
    apb(1'b1, 12'h080, 32'hff, d, e);
    apb(1'b0, 12'h080, 32'h0, d, e); `CHECK("control readback", 32'hfb, d)
    `CHECK("readback accepted", 1'b0, e)
    apb(1'b0, 12'h004, 32'h0, d, e); `CHECK("unmapped error", 1'b1, e)
    apb(1'b0, 12'h07d, 32'h0, d, e); `CHECK("misaligned error", 1'b1, e)
    apb(1'b1, 12'h0c0, 32'hff, d, e); `CHECK("status write error", 1'b1, e)
    apb(1'b1, 12'h078, 32'h0, d, e);
    apb(1'b1, 12'h07c, 32'h3c, d, e);
    // Power-up with calibration enabled; software keeps resolution at 0, 1 or 2
    apb(1'b1, 12'h080, 32'h08, d, e);
    #1 `CHECK("cal busy", 1'b1, events.cal_busy)
    apb(1'b0, 12'h0c0, 32'h0, d, e); `CHECK("status calibrating", 32'h01, d)
    wait_for(2, n); `CHECK("cal length", 1'b1, n <= CALP * DIV + 4)
    apb(1'b0, 12'h0c0, 32'h0, d, e); `CHECK("status running", 32'h02, d)
    wait_for(0, n);
    wait_for(0, n); `CHECK("wake period", 60 * DIV, n)
    // Every second-event delay code, one tick of slack either way
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h080, 32'(c) << 4, d, e);
      wait_for(0, n);
      wait_for(1, n); `CHECK("second delay", 1'b1, n >= (dly[c] - 1) * DIV && n <= (dly[c] + 1) * DIV)
    end
    // Code 3 is left out: one period would outlast the whole run
    apb(1'b1, 12'h07c, 32'h01, d, e);
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, 12'h080, 32'(r), d, e);
      wait_for(0, n);
      wait_for(0, n); `CHECK("resolution period", step[r] * DIV, n)
    end
    apb(1'b1, 12'h080, 32'h80, d, e);
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (events.wake_event !== 1'b0) n++;
    end
    `CHECK("wakes while down", 0, n)
    apb(1'b0, 12'h0c0, 32'h0, d, e); `CHECK("status stopped", 32'h00, d)
    // Reset in mid-run restores interval low and the control register
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h07c, 32'h0, d, e); `CHECK("low after reset", 32'h6b, d)
    apb(1'b0, 12'h080, 32'h0, d, e); `CHECK("control after reset", 32'hf8, d)
    `CHECK("powerdown after reset", 1'b1, events.rc_osc_powerdown)
    summarize();
  end

  // Watchdog well past the expected run of about 11500 cycles
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule : wake_on_radio_timer_tb_top
